// ===== hdl/tpwm_timer.sv
// Functional notes
// R1: pin carries pwm when enabled plus pwm bit
// R2: each period is high then low
// R3: rate sets period, bits resolution, reload duty
// R4: pwm counter starts at zero on enable
// R5: count equal to duty ends high pulse
// R6: wrap ends period, output returns high
// R7: new duty applies from next period
// R8: resolution pair 00/01/10/11 gives 256/64/32/16
// R9: overflow sets flag; enable raises request
// R10: pwm bit takes pin; clear returns gpio; code takes the pin for pwm only while the timer is also enabled, the toggle output takes it without
// R11: software rescales duty on resolution change
// R12: software follows interval timer setup order
// R13: clock source bit selects event pin
// R14: software follows toggle output setup order
// R15: software follows pwm setup order
// R16: rate field divides clock 256 down to 2
// R17: event mode counts falling edges of pin
// R18: reload write buffered until next overflow
// R19: toggle output inverts pin every overflow
// R20: reduced resolution wraps at 64/32/16 counts
// R21: internal mode counts prescaled ticks
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`default_nettype none

module tpwm_timer (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // axi4-lite write address
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // gpio side of the shared pin
   input wire logic gpio_out,
   input wire logic gpio_oe,
   // pins
   input wire logic event_input_pin,
   output logic pwm_output_pin_o,
   output logic pwm_output_pin_oe,
   // interrupt request
   output logic timer_irq
);

   // ==========================================
   // reset release
   logic rst_meta_r;
   logic rst_n;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   // ==========================================
   // state
   logic [7:0] timer_ctrl_reg;
   logic [7:0] timer_count_reg;
   logic [7:0] timer_reload_reg;
   logic [7:0] reload_act_r;
   logic timer_irq_flag;
   logic timer_irq_enable;
   logic evt_prev_r;
   logic run_pwm_prev_r;
   logic tog_r;

   logic pwm_output_enable;
   logic toggle_output_enable;
   logic auto_reload_enable;
   logic clock_source_sel;
   logic timer_enable_bit;
   logic [2:0] prescale_rate_sel;

   assign pwm_output_enable = timer_ctrl_reg[tpwm_pkg::CTRL_PWM_BIT];
   assign toggle_output_enable = timer_ctrl_reg[tpwm_pkg::CTRL_TOG_BIT];
   assign auto_reload_enable = timer_ctrl_reg[tpwm_pkg::CTRL_ALOAD_BIT];
   assign clock_source_sel = timer_ctrl_reg[tpwm_pkg::CTRL_CKS_BIT];
   assign timer_enable_bit = timer_ctrl_reg[tpwm_pkg::CTRL_ENB_BIT];
   assign prescale_rate_sel = timer_ctrl_reg[tpwm_pkg::CTRL_RATE_MSB:tpwm_pkg::CTRL_RATE_LSB];

   // ==========================================
   // axi write channel
   logic aw_full_r;
   logic w_full_r;
   logic [4:0] waddr_r;
   logic [7:0] wbyte_r;
   logic wlane_r;
   logic wr_fire;
   logic wr_ctrl;
   logic wr_count;
   logic wr_reload;
   logic wr_irq;

   assign wr_fire = aw_full_r && w_full_r && !s_axi_bvalid;
   assign wr_ctrl = wr_fire && wlane_r && waddr_r == tpwm_pkg::OFF_CTRL;
   assign wr_count = wr_fire && wlane_r && waddr_r == tpwm_pkg::OFF_COUNT;
   assign wr_reload = wr_fire && wlane_r && waddr_r == tpwm_pkg::OFF_RELOAD;
   assign wr_irq = wr_fire && wlane_r && waddr_r == tpwm_pkg::OFF_IRQ;

   // address and data taken in either order, answer after both
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         waddr_r <= 5'h00;
         wbyte_r <= 8'h00;
         wlane_r <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= tpwm_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            waddr_r <= {s_axi_awaddr[4:2], 2'b00};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            wbyte_r <= s_axi_wdata[7:0];
            wlane_r <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= waddr_r[4] ? tpwm_pkg::RESP_SLVERR : tpwm_pkg::RESP_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ==========================================
   // axi read channel
   logic [4:0] raddr;

   assign raddr = {s_axi_araddr[4:2], 2'b00};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= tpwm_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= tpwm_pkg::RESP_OKAY;
         unique case (raddr)
            tpwm_pkg::OFF_CTRL: s_axi_rdata <= {24'h00_0000, timer_ctrl_reg};
            tpwm_pkg::OFF_COUNT: s_axi_rdata <= {24'h00_0000, timer_count_reg};
            // reload is write-only, reads zero
            tpwm_pkg::OFF_RELOAD: s_axi_rdata <= 32'h0000_0000;
            tpwm_pkg::OFF_IRQ: s_axi_rdata <= {30'h0000_0000, timer_irq_enable, timer_irq_flag};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= tpwm_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ==========================================
   // control register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_ctrl_reg <= tpwm_pkg::RST_CTRL;
      end else if (wr_ctrl) begin
         timer_ctrl_reg <= wbyte_r;
      end
   end

   // ==========================================
   // clock source
   logic pre_tick;
   logic evt_fall;
   logic tick;

   tpwm_prescale u_prescale (
      .clk(clk),
      .rst_n(rst_n),
      .run(timer_enable_bit && !clock_source_sel),
      .rate(prescale_rate_sel),
      .tick(pre_tick)
   );

   // pin is taken as synchronous, so no synchroniser here
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         evt_prev_r <= 1'b1;
      end else begin
         evt_prev_r <= event_input_pin;
      end
   end

   assign evt_fall = evt_prev_r && !event_input_pin; // R17
   assign tick = timer_enable_bit && (clock_source_sel ? evt_fall : pre_tick); // R13 R21

   // ==========================================
   // resolution and overflow
   logic [7:0] res_mask;
   logic ovf;
   logic run_pwm;
   logic pwm_start;

   always_comb begin
      res_mask = tpwm_pkg::RES_MASK_256;
      // event mode always runs the full 8 bits
      if (pwm_output_enable && !clock_source_sel) begin
         unique case ({auto_reload_enable, toggle_output_enable}) // R3 R8
            2'b00: res_mask = tpwm_pkg::RES_MASK_256;
            2'b01: res_mask = tpwm_pkg::RES_MASK_64;
            2'b10: res_mask = tpwm_pkg::RES_MASK_32;
            2'b11: res_mask = tpwm_pkg::RES_MASK_16;
         endcase
      end
   end

   assign ovf = tick && ((timer_count_reg & res_mask) == res_mask); // R6 R20
   assign run_pwm = timer_enable_bit && pwm_output_enable;
   assign pwm_start = run_pwm && !run_pwm_prev_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_pwm_prev_r <= 1'b0;
      end else begin
         run_pwm_prev_r <= run_pwm;
      end
   end

   // ==========================================
   // counter; a software write wins over counting
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_count_reg <= tpwm_pkg::RST_COUNT;
      end else if (wr_count) begin
         timer_count_reg <= wbyte_r;
      end else if (pwm_start) begin
         timer_count_reg <= 8'h00; // R4
      end else if (ovf) begin
         if (pwm_output_enable) begin
            timer_count_reg <= 8'h00; // R4 R6
         end else if (auto_reload_enable) begin
            timer_count_reg <= timer_reload_reg; // R18
         end else begin
            timer_count_reg <= 8'h00;
         end
      end else if (tick) begin
         timer_count_reg <= (timer_count_reg + 8'h01) & res_mask; // R21 R17 R20
      end
   end

   // ==========================================
   // reload double buffer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_reload_reg <= tpwm_pkg::RST_RELOAD;
      end else if (wr_reload) begin
         timer_reload_reg <= wbyte_r; // R18
      end
   end

   // while stopped the buffer passes straight through, so setup is seen at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reload_act_r <= tpwm_pkg::RST_RELOAD;
      end else if (!timer_enable_bit || ovf) begin
         reload_act_r <= timer_reload_reg; // R7 R18
      end
   end

   // ==========================================
   // interrupt flag: overflow wins over a clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_irq_flag <= 1'b0;
         timer_irq_enable <= 1'b0;
         timer_irq <= 1'b0;
      end else begin
         if (ovf) begin
            timer_irq_flag <= 1'b1; // R9
         end else if (wr_irq && !wbyte_r[tpwm_pkg::IRQ_FLAG_BIT]) begin
            timer_irq_flag <= 1'b0;
         end
         if (wr_irq) begin
            timer_irq_enable <= wbyte_r[tpwm_pkg::IRQ_EN_BIT];
         end
         timer_irq <= timer_irq_flag && timer_irq_enable; // R9
      end
   end

   // ==========================================
   // toggle output
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tog_r <= 1'b0;
      end else if (ovf && toggle_output_enable && !pwm_output_enable) begin
         tog_r <= !tog_r; // R19
      end
   end

   // ==========================================
   // pin mux; duty 0 keeps the pin low all period
   logic pwm_hi;

   assign pwm_hi = (timer_count_reg & res_mask) < (reload_act_r & res_mask); // R2 R5

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwm_output_pin_o <= 1'b0;
         pwm_output_pin_oe <= 1'b0;
      end else if (run_pwm) begin
         pwm_output_pin_o <= pwm_hi; // R1
         pwm_output_pin_oe <= 1'b1;
      end else if (toggle_output_enable && !pwm_output_enable) begin
         pwm_output_pin_o <= tog_r; // R19
         pwm_output_pin_oe <= 1'b1;
      end else begin
         pwm_output_pin_o <= gpio_out; // R10
         pwm_output_pin_oe <= gpio_oe;
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_PWM_DRIVES_PIN: assert property ( // R1
      run_pwm |=> pwm_output_pin_oe)
      else $error("pwm running but pin not driven");

   AST_PERIOD_STARTS_HIGH: assert property ( // R2
      (run_pwm && (timer_count_reg & res_mask) == 8'h00 && (reload_act_r & res_mask) != 8'h00)
      |=> pwm_output_pin_o)
      else $error("pwm period did not start high");

   AST_DUTY_ENDS_HIGH: assert property ( // R5
      (run_pwm && (timer_count_reg & res_mask) >= (reload_act_r & res_mask)) |=> !pwm_output_pin_o)
      else $error("pwm still high at or past duty");

   AST_START_AT_ZERO: assert property ( // R4
      (pwm_start && !wr_count) |=> timer_count_reg == 8'h00)
      else $error("pwm did not start from zero");

   AST_WRAP_TO_ZERO: assert property ( // R6
      (ovf && pwm_output_enable && !wr_count && !pwm_start) |=> timer_count_reg == 8'h00 ##1 1'b1)
      else $error("pwm overflow did not restart at zero");

   AST_RELOAD_DEFERRED: assert property ( // R7
      (timer_enable_bit && !ovf) |=> $stable(reload_act_r))
      else $error("active duty changed mid period");

   AST_OVF_SETS_FLAG: assert property ( // R9
      ovf |=> timer_irq_flag ##1 (timer_irq == timer_irq_enable))
      else $error("overflow did not set flag or request");

   AST_TOGGLE_FLIPS: assert property ( // R19
      (ovf && toggle_output_enable && !pwm_output_enable) |=> tog_r != $past(tog_r))
      else $error("toggle output did not invert");

   AST_COUNT_STEP: assert property ( // R21
      (tick && !ovf && !wr_count && !pwm_start) |=> timer_count_reg == 8'($past(timer_count_reg) + 8'h01))
      else $error("counter did not advance by one");

   AST_GPIO_RETURN: assert property ( // R10
      (!run_pwm && !toggle_output_enable) |=> pwm_output_pin_o == $past(gpio_out))
      else $error("pin not returned to gpio");

   COV_PWM_OVF: cover property (run_pwm && ovf);
   COV_TOGGLE: cover property (ovf && toggle_output_enable && !pwm_output_enable);
   COV_IRQ: cover property ($rose(timer_irq));
   COV_EVENT: cover property (clock_source_sel && tick);

endmodule : tpwm_timer

`default_nettype wire

// ===== hdl/tpwm_pkg.sv
`default_nettype none

package tpwm_pkg;

   // ==========================================
   // register map (byte addresses)
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_COUNT = 5'h04;
   localparam logic [4:0] OFF_RELOAD = 5'h08;
   localparam logic [4:0] OFF_IRQ = 5'h0c;

   // ==========================================
   // control register fields
   localparam int CTRL_PWM_BIT = 0;
   localparam int CTRL_TOG_BIT = 1;
   localparam int CTRL_ALOAD_BIT = 2;
   localparam int CTRL_CKS_BIT = 3;
   localparam int CTRL_RATE_LSB = 4;
   localparam int CTRL_RATE_MSB = 6;
   localparam int CTRL_ENB_BIT = 7;

   // irq register fields
   localparam int IRQ_FLAG_BIT = 0;
   localparam int IRQ_EN_BIT = 1;

   // ==========================================
   // reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_RELOAD = 8'h00;

   // ==========================================
   // overflow masks per resolution
   localparam logic [7:0] RES_MASK_256 = 8'hff;
   localparam logic [7:0] RES_MASK_64 = 8'h3f;
   localparam logic [7:0] RES_MASK_32 = 8'h1f;
   localparam logic [7:0] RES_MASK_16 = 8'h0f;

   // prescaler full divide (fcpu/256)
   localparam logic [7:0] PRESCALE_FULL = 8'hff;

   // ==========================================
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : tpwm_pkg

`default_nettype wire

// ===== hdl/tpwm_prescale.sv
`default_nettype none

module tpwm_prescale (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic run,
   input wire logic [2:0] rate,
   // tick out
   output logic tick
);

   logic [7:0] div_r;
   logic [7:0] mask;

   // rate 0 divides by 256, each step halves the divisor
   assign mask = tpwm_pkg::PRESCALE_FULL >> rate; // R16

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= 8'h00;
      end else if (!run) begin
         div_r <= 8'h00;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick <= 1'b0;
      end else begin
         tick <= run && ((div_r & mask) == mask); // R16
      end
   end

   // ==========================================
   // checks
   AST_DIV2_SPACING: assert property (@(posedge clk) disable iff (!rst_n) // R16
      (run && rate == 3'h7 && tick) ##1 (run && rate == 3'h7) |-> !tick)
      else $error("divide by 2 ticked on consecutive cycles");

endmodule : tpwm_prescale

`default_nettype wire

// ===== dv/tpwm_load_model.sv
`default_nettype none

module tpwm_load_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pin from the block
   input wire logic pin_o,
   input wire logic pin_oe,
   // measurements
   output logic level,
   output logic [15:0] hi_len,
   output logic [15:0] per_len
);
   timeunit 1ns;
   timeprecision 1ps;

   logic prev_r;
   logic [15:0] cnt_r;

   // ==========================================
   // line level
   // the load pulls the line low while nobody drives it
   assign level = pin_oe ? pin_o : 1'b0;

   // ==========================================
   // width measurement
   // one counter serves both: restarted at each rise, read at fall and at rise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 1'b0;
         cnt_r <= 16'h0;
         hi_len <= 16'h0;
         per_len <= 16'h0;
      end else begin
         prev_r <= level;
         cnt_r <= (level && !prev_r) ? 16'h1 : cnt_r + 16'h1;
         if (!level && prev_r) begin
            hi_len <= cnt_r;
         end
         if (level && !prev_r) begin
            per_len <= cnt_r;
         end
      end
   end

endmodule : tpwm_load_model

`default_nettype wire

// ===== dv/test_timer_pwm_generator.sv
`default_nettype none

`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end

module test_timer_pwm_generator;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================
   // signals
   logic clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, gpio_out, gpio_oe, event_input_pin;
   logic pwm_output_pin_o, pwm_output_pin_oe, timer_irq, level;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [15:0] hi_len, per_len;
   int n_errors, comparisons;

   localparam logic [7:0] PWM = 8'h01 << tpwm_pkg::CTRL_PWM_BIT;
   localparam logic [7:0] TOG = 8'h01 << tpwm_pkg::CTRL_TOG_BIT;
   localparam logic [7:0] ALD = 8'h01 << tpwm_pkg::CTRL_ALOAD_BIT;
   localparam logic [7:0] CKS = 8'h01 << tpwm_pkg::CTRL_CKS_BIT;
   localparam logic [7:0] ENB = 8'h01 << tpwm_pkg::CTRL_ENB_BIT;
   localparam logic [7:0] RT7 = 8'h07 << tpwm_pkg::CTRL_RATE_LSB;

   tpwm_timer u_tpwm_timer (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gpio_out,
      .gpio_oe, .event_input_pin, .pwm_output_pin_o, .pwm_output_pin_oe, .timer_irq);

   tpwm_load_model u_tpwm_load_model (.clk, .rst_n(rstn), .pin_o(pwm_output_pin_o),
      .pin_oe(pwm_output_pin_oe), .level, .hi_len, .per_len);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========================================
   // bus and pin helpers
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge clk);
         if (!ad && s_axi_awready === 1'b1) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wd && s_axi_wready === 1'b1) begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      // bready stays high: dropping it here would clash with the next call raising it
      resp = s_axi_bresp;
   endtask : wr

   task automatic rdr(input logic [4:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
   endtask : rdr

   // bounded wait for a line level; a hang shows as a mismatch
   task automatic wl(input logic v);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (level !== v && n < 3000);
      `CHK(level, v)
   endtask : wl

   // first period may be cut short by the start; both widths come from the second
   task automatic meas;
      wl(1'b1);
      wl(1'b0);
      wl(1'b1);
      wl(1'b0);
      wl(1'b1);
      @(posedge clk);
   endtask : meas

   task automatic pwm_on(input logic [7:0] res, input logic [7:0] duty);
      wr(tpwm_pkg::OFF_CTRL, 8'h00);
      wr(tpwm_pkg::OFF_CTRL, RT7);
      wr(tpwm_pkg::OFF_CTRL, RT7 | res);
      wr(tpwm_pkg::OFF_RELOAD, duty);
      wr(tpwm_pkg::OFF_COUNT, 8'h00);
      wr(tpwm_pkg::OFF_CTRL, RT7 | res | ENB);
      wr(tpwm_pkg::OFF_CTRL, RT7 | res | ENB | PWM);
   endtask : pwm_on

   // ==========================================
   // scenarios
   task automatic t_regs;
      rdr(tpwm_pkg::OFF_CTRL);
      `CHK(rd, 32'h0)
      rdr(tpwm_pkg::OFF_COUNT);
      `CHK(rd, 32'h0)
      rdr(tpwm_pkg::OFF_RELOAD);
      `CHK(rd, 32'h0)
      rdr(tpwm_pkg::OFF_IRQ);
      `CHK(rd, 32'h0)
      rdr(5'h10);
      `CHK(resp, tpwm_pkg::RESP_SLVERR)
      wr(5'h14, 8'hff);
      `CHK(resp, tpwm_pkg::RESP_SLVERR)
      `CHK(pwm_output_pin_oe, 1'b0)
      $display("test regs done");
   endtask : t_regs

   // count written nonzero on purpose: enabling pwm must zero it
   task automatic t_start;
      wr(tpwm_pkg::OFF_CTRL, 8'h00);
      wr(tpwm_pkg::OFF_COUNT, 8'h55);
      wr(tpwm_pkg::OFF_CTRL, ENB | PWM);
      rdr(tpwm_pkg::OFF_COUNT);
      `CHK(rd, 32'h0)
      $display("test start done");
   endtask : t_start

   task automatic t_res;
      int n;
      for (int i = 0; i < 4; i++) begin
         n = 256 >> (i == 0 ? 0 : i + 1);
         pwm_on((i[1] ? ALD : 8'h00) | (i[0] ? TOG : 8'h00), 8'(n / 4));
         meas();
         `CHK(hi_len, 16'(n / 2))
         `CHK(per_len, 16'(2 * n))
         `CHK(pwm_output_pin_oe, 1'b1)
      end
      $display("test resolution done");
   endtask : t_res

   task automatic t_duty;
      pwm_on(8'h00, 8'h40);
      wl(1'b0);
      wl(1'b1);
      wr(tpwm_pkg::OFF_RELOAD, 8'h80);
      wl(1'b0);
      @(posedge clk);
      `CHK(hi_len, 16'd128)
      wl(1'b1);
      wl(1'b0);
      @(posedge clk);
      `CHK(hi_len, 16'd256)
      `CHK(per_len, 16'd512)
      $display("test duty done");
   endtask : t_duty

   task automatic t_irq;
      wl(1'b0);
      wl(1'b1);
      wr(tpwm_pkg::OFF_IRQ, 8'h02);
      repeat (2) @(posedge clk);
      `CHK(timer_irq, 1'b0)
      wl(1'b0);
      wl(1'b1);
      repeat (3) @(posedge clk);
      `CHK(timer_irq, 1'b1)
      rdr(tpwm_pkg::OFF_IRQ);
      `CHK(rd, 32'h3)
      wr(tpwm_pkg::OFF_IRQ, 8'h00);
      repeat (2) @(posedge clk);
      `CHK(timer_irq, 1'b0)
      $display("test irq done");
   endtask : t_irq

   task automatic t_gpio;
      logic [31:0] a;
      gpio_out <= 1'b1;
      gpio_oe <= 1'b1;
      wr(tpwm_pkg::OFF_CTRL, RT7 | ENB);
      repeat (2) @(posedge clk);
      `CHK(level, 1'b1)
      gpio_out <= 1'b0;
      gpio_oe <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(pwm_output_pin_oe, 1'b0)
      rdr(tpwm_pkg::OFF_COUNT);
      a = rd;
      rdr(tpwm_pkg::OFF_COUNT);
      `CHK(rd != a, 1'b1)
      $display("test gpio done");
   endtask : t_gpio

   // toggle output over every rate: two ticks per overflow
   task automatic t_rate;
      logic [7:0] c;
      for (int r = 0; r < 8; r++) begin
         c = (8'(r) << tpwm_pkg::CTRL_RATE_LSB) | ALD;
         wr(tpwm_pkg::OFF_CTRL, 8'h00);
         wr(tpwm_pkg::OFF_CTRL, c);
         wr(tpwm_pkg::OFF_COUNT, 8'hfe);
         wr(tpwm_pkg::OFF_RELOAD, 8'hfe);
         wr(tpwm_pkg::OFF_CTRL, c | ENB);
         wr(tpwm_pkg::OFF_CTRL, c | ENB | TOG);
         meas();
         `CHK(hi_len, 16'(2 * (256 >> r)))
         `CHK(per_len, 16'(4 * (256 >> r)))
      end
      $display("test rate done");
   endtask : t_rate

   task automatic t_event;
      wr(tpwm_pkg::OFF_CTRL, 8'h00);
      wr(tpwm_pkg::OFF_COUNT, 8'h00);
      wr(tpwm_pkg::OFF_CTRL, CKS | ENB);
      repeat (5) begin
         event_input_pin <= 1'b1;
         repeat (2) @(posedge clk);
         event_input_pin <= 1'b0;
         repeat (2) @(posedge clk);
      end
      rdr(tpwm_pkg::OFF_COUNT);
      `CHK(rd, 32'h5)
      $display("test event done");
   endtask : t_event

   // ==========================================
   // run control
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready, s_axi_araddr,
         s_axi_arvalid, s_axi_rready, gpio_out, gpio_oe, event_input_pin, rstn} = '0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs();
      t_start();
      t_res();
      t_duty();
      t_irq();
      t_gpio();
      t_rate();
      t_event();
      conclude();
   end

   // about seven times the expected run length
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      conclude();
   end

endmodule : test_timer_pwm_generator

`default_nettype wire
